// file: tb/fbl_host_loader_properties.sv
// fbl_host_loader_properties: port-level protocol checks for the host loader
`timescale 1ns/100ps
`default_nettype none
module fbl_host_loader_properties import fbl_pkg::*; (
	// clock and reset
	input wire logic          i_clk,
	input wire logic          i_rst,
	// user side
	input wire logic          i_start,
	input wire logic          i_abort,
	// modem pins and status
	input wire logic          i_boot_enable_gpio,
	input wire logic          o_modem_reset_n,
	input wire fbl_strap_type o_strap,
	input wire logic          o_boot_enable_gpio_out,
	input wire logic          o_boot_enable_gpio_oe,
	input wire logic          o_uart_tx,
	input wire logic          o_busy,
	input wire logic          o_done,
	input wire logic          o_fail,
	input wire logic          o_boot_enable_level
);
	// ****************
	// helper counter
	// ****************
	logic [15:0] hold_q;   // cycles of modem reset in this boot
	logic [15:0] hold_d;
	// counts only while busy, so a refused start never adds up
	always_comb begin
		hold_d = hold_q;
		if (i_rst || !o_busy) begin
			hold_d = 16'h0000;
		end else if (!o_modem_reset_n) begin
			hold_d = hold_q + 16'h0001;
		end
	end
	always_ff @(posedge i_clk) begin
		hold_q <= hold_d;
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_serial_boot;   // serial upload under way
		o_busy && !o_strap.boot_source_select;
	endsequence
	sequence s_start_bit;     // host begins a frame
		$fell(o_uart_tx) ##0 o_busy;
	endsequence
	a_start_taken: assert property (i_start && !o_busy |=> o_busy || o_fail)
		else $error("start not taken");
	a_reset_hold: assert property ($rose(o_modem_reset_n) |->
		hold_q inside {[RST_HOLD_CYC:RST_HOLD_CYC + 1]})
		else $error("modem reset pulse length wrong");
	a_strap_stable: assert property (o_busy && $past(o_busy) |-> $stable(o_strap))
		else $error("straps moved during boot");
	a_enable_low: assert property (s_serial_boot |->
		o_boot_enable_gpio_oe && !o_boot_enable_gpio_out)
		else $error("enable pin not held low");
	a_abort_fail: assert property (s_serial_boot ##0 i_abort |=>
		o_fail && o_boot_enable_gpio_out)
		else $error("abort did not raise pin and fail");
	a_start_bit: assert property (s_start_bit |-> !o_uart_tx [*8])
		else $error("start bit too short");
	a_done_release: assert property ($rose(o_done) |->
		o_modem_reset_n && !o_boot_enable_gpio_oe)
		else $error("done without releasing pin");
	a_no_early_tx: assert property (!o_modem_reset_n |-> o_uart_tx)
		else $error("host sent while modem in reset");
	a_level_follow: assert property (i_boot_enable_gpio [*5] |->
		o_boot_enable_level)
		else $error("pin level not reported");
endmodule // fbl_host_loader_properties

bind fbl_host_loader fbl_host_loader_properties u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_abort(i_abort),
	.i_boot_enable_gpio(i_boot_enable_gpio), .o_modem_reset_n(o_modem_reset_n),
	.o_strap(o_strap), .o_boot_enable_gpio_out(o_boot_enable_gpio_out),
	.o_boot_enable_gpio_oe(o_boot_enable_gpio_oe), .o_uart_tx(o_uart_tx), .o_busy(o_busy),
	.o_done(o_done), .o_fail(o_fail), .o_boot_enable_level(o_boot_enable_level));
`default_nettype wire

// file: tb/fbl_host_loader_tb_top.sv
// fbl_host_loader_tb_top: scenario bench for the host firmware loader
`timescale 1ns/100ps
`default_nettype none
module fbl_host_loader_tb_top import fbl_pkg::*;;
	logic clk, rst, start, from_memory, abort, img_we;
	logic [1:0] baud_code;
	logic [15:0] image_len;
	logic [14:0] img_addr;
	logic [7:0] img_data;
	logic reset_n, gpio_out, gpio_oe, gpio_pin, utx, urx, busy, done, fail, level;
	logic nak_first, released;
	logic [3:0] nak_count, ce_count;
	fbl_strap_type strap;
	int n_mismatch = 0;
	int compares = 0;
	localparam logic [7:0] IMG [0:2] = '{8'h3C, 8'hA5, 8'h0F};
	// enable pin has a pull-down when nobody drives it
	assign gpio_pin = gpio_oe ? gpio_out : 1'b0;
	fbl_host_loader #(.STX_WAIT_CYCLES(20000), .DONE_QUIET_CYCLES(5000),
		.EXT_WAIT_CYCLES(100)) uut (
		.i_clk(clk), .i_rst(rst), .i_start(start), .i_from_memory(from_memory),
		.i_baud_code(baud_code), .i_image_len(image_len), .i_abort(abort),
		.i_img_we(img_we), .i_img_addr(img_addr), .i_img_data(img_data),
		.o_modem_reset_n(reset_n), .o_strap(strap), .o_boot_enable_gpio_out(gpio_out),
		.o_boot_enable_gpio_oe(gpio_oe), .i_boot_enable_gpio(gpio_pin), .o_uart_tx(utx),
		.i_uart_rx(urx), .o_busy(busy), .o_done(done), .o_fail(fail),
		.o_nak_count(nak_count), .o_boot_enable_level(level));
	fbl_modem_model modem (.i_clk(clk), .i_reset_n(reset_n), .i_strap(strap),
		.i_boot_enable_gpio(gpio_pin), .i_rxd(utx), .o_txd(urx),
		.i_nak_first(nak_first), .o_released(released), .o_ce_count(ce_count));
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic boot(input logic mem, input logic [1:0] code, input logic [15:0] len);
		@(negedge clk);
		from_memory = mem;
		baud_code = code;
		image_len = len;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask
	// bounded wait for the end of a boot
	task automatic wait_end(input int lim);
		int n;
		for (n = 0; n < lim && done !== 1'b1 && fail !== 1'b1; n++) @(negedge clk);
		if (n >= lim) begin
			n_mismatch++;
			$display("[FAIL] boot end expected done seen busy");
			finish_test();
		end
	endtask
	task automatic t_mem();
		for (int c = 0; c < 4; c++) begin
			boot(1'b1, 2'(c), 16'h0003);
			chk("memory straps", 16'({1'b1, 2'(c)}), 16'(strap));
			chk("pin and reset", 16'h0, 16'({gpio_pin, reset_n}));
			wait_end(1000);
			chk("memory end", 16'h4, 16'({done, fail, gpio_oe}));
		end
	endtask
	task automatic t_serial(input logic nak);
		nak_first = nak;
		boot(1'b0, 2'h0, 16'h0003);
		chk("serial straps", 16'h0, 16'(strap));
		chk("pin driven low", 16'h2, 16'({gpio_oe, gpio_out}));
		wait_end(60000);
		chk("serial end", 16'h2, 16'({done, fail}));
		chk("naks", 16'(nak), 16'(nak_count));
		chk("clear errors", 16'(nak), 16'(ce_count));
		chk("modem released", 16'h1, 16'(released));
		for (int i = 0; i < 3; i++) chk("image byte", 16'(IMG[i]), 16'(modem.img[i]));
	endtask
	task automatic t_refuse();
		boot(1'b0, 2'h0, 16'h0000);
		chk("empty image", 16'h4, 16'({fail, reset_n, gpio_oe}));
		boot(1'b0, 2'h0, 16'h7EFF);
		chk("oversize", 16'h4, 16'({fail, reset_n, gpio_oe}));
	endtask
	task automatic t_abort();
		boot(1'b0, 2'h0, 16'h0003);
		cyc(400);
		abort = 1'b1;
		cyc(6);
		chk("abort", 16'h7, 16'({fail, gpio_out, level}));
		abort = 1'b0;
		cyc(4000);
		chk("modem stopped", 16'h0, 16'(released));
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst, start, from_memory, abort, img_we, nak_first} = 6'h20;
		baud_code = 2'h0;
		image_len = 16'h0000;
		img_addr = 15'h0000;
		img_data = 8'h00;
		cyc(2);
		rst = 1'b0;
		cyc(1);
		chk("reset state", 16'h1, 16'({reset_n, strap, busy, done, fail, nak_count, utx}));
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			img_we = 1'b1;
			img_addr = 15'(i);
			img_data = IMG[i];
		end
		@(negedge clk);
		img_we = 1'b0;
		t_mem();
		t_serial(1'b0);
		t_serial(1'b1);
		t_refuse();
		t_abort();
		finish_test();
	end
endmodule // fbl_host_loader_tb_top
`default_nettype wire

// file: tb/fbl_modem_model.sv
// fbl_modem_model: behavioural modem boot loader, serial upload side only
`timescale 1ns/100ps
`default_nettype none
module fbl_modem_model import fbl_pkg::*; #(
	parameter int QUIET_CYC = 2000   // scaled idle wait after a nak
) (
	// modem pins
	input  wire logic          i_clk,
	input  wire logic          i_reset_n,
	input  wire fbl_strap_type i_strap,
	input  wire logic          i_boot_enable_gpio,
	input  wire logic          i_rxd,
	output logic               o_txd,
	// scenario control and status
	input  wire logic          i_nak_first,
	output logic               o_released,
	output logic [3:0]         o_ce_count
);
	logic [11:0] div;        // clocks per bit, fixed at reset release
	logic [7:0]  img [0:15]; // first image bytes seen
	logic [7:0]  b;
	logic [15:0] size;
	logic [15:0] crc;
	logic [15:0] got;
	logic        ok;
	int          tries;
	// own crc, kept apart from the host's code on purpose
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ CRC_POLY_DEF) : (c << 1);
		end
		return c;
	endfunction
	// one frame, lsb first, idle high after the stop bit; returns mid stop bit,
	// so a reply that starts at once is caught from its own start bit
	task automatic tx(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_txd <= f[i];
			repeat ((i == 9) ? div / 2 : div) @(posedge i_clk);
		end
	endtask
	// waits for a frame; gives up on a raised enable pin or silence
	task automatic rx(output logic good, output logic [7:0] v);
		int n;
		good = 1'b0;
		v = 8'h00;
		for (n = 0; n < 60000 && i_rxd; n++) begin
			@(posedge i_clk);
			if (i_boot_enable_gpio) return;
		end
		if (i_rxd) return;
		repeat (div / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge i_clk);
			v[i] = i_rxd;
		end
		repeat (div) @(posedge i_clk);
		good = i_rxd;
	endtask
	// nak, then drop everything until the line rests
	task automatic nak();
		int idle;
		tx(NAK_BYTE);
		idle = 0;
		while (idle < QUIET_CYC) begin
			@(posedge i_clk);
			idle = i_rxd ? idle + 1 : 0;
		end
	endtask
	task automatic load();
		forever begin
			repeat (20) @(posedge i_clk);
			tx(STX_BYTE);
			rx(ok, b);
			if (ok && b == CLEAR_ERR_BYTE) begin
				o_ce_count = o_ce_count + 4'h1;
				rx(ok, b);
			end
			if (!ok || b != MAGIC_BYTE) return;
			rx(ok, size[7:0]);
			rx(ok, size[15:8]);
			if (size > MAX_IMAGE) begin
				nak();
				continue;
			end
			crc = CRC_INIT_DEF;
			for (int i = 2; i < int'(size); i++) begin
				rx(ok, b);
				if (!ok) return;
				if (i < 18) img[i - 2] = b;
				crc = crc_byte(crc, b);
			end
			rx(ok, got[7:0]);
			rx(ok, got[15:8]);
			if (got !== crc || (i_nak_first && tries == 0)) begin
				tries++;
				nak();
			end else begin
				o_released = 1'b1;
				return;
			end
		end
	endtask
	// straps read once per reset release
	initial begin
		o_txd <= 1'b1;
		o_released = 1'b0;
		o_ce_count = 4'h0;
		forever begin
			@(posedge i_reset_n);
			o_released = 1'b0;
			o_ce_count = 4'h0;
			tries = 0;
			case ({i_strap.baud_select_high, i_strap.baud_select_low})
				2'h1: div = DIV_9600;
				2'h2: div = DIV_19200;
				2'h3: div = DIV_38400;
				default: div = DIV_115200;
			endcase
			// memory boot over the dedicated port is not modelled
			if (!i_strap.boot_source_select) load();
		end
	end
endmodule // fbl_modem_model
`default_nettype wire

// file: verilog/fbl_host_loader.sv
// fbl_host_loader: host that straps, resets and feeds firmware to the modem
`timescale 1ns/100ps
`default_nettype none
module fbl_host_loader import fbl_pkg::*; #(
	parameter int unsigned MAX_IMAGE_BYTES   = MAX_IMAGE,
	parameter int unsigned STX_WAIT_CYCLES   = STX_WAIT_CYC,
	parameter int unsigned DONE_QUIET_CYCLES = DONE_QUIET_CYC,
	parameter int unsigned EXT_WAIT_CYCLES   = EXT_WAIT_CYC,
	parameter logic [3:0]  MAX_RETRY         = 4'h3,
	parameter logic [15:0] CRC_POLY          = CRC_POLY_DEF,
	parameter logic [15:0] CRC_INIT          = CRC_INIT_DEF
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// user commands
	input  wire logic          i_start,
	input  wire logic          i_from_memory,
	input  wire logic [1:0]    i_baud_code,
	input  wire logic [15:0]   i_image_len,
	input  wire logic          i_abort,
	// image load port
	input  wire logic          i_img_we,
	input  wire logic [14:0]   i_img_addr,
	input  wire logic [7:0]    i_img_data,
	// modem pins
	output logic               o_modem_reset_n,
	output fbl_strap_type      o_strap,
	output logic               o_boot_enable_gpio_out,
	output logic               o_boot_enable_gpio_oe,
	input  wire logic          i_boot_enable_gpio,
	output logic               o_uart_tx,
	input  wire logic          i_uart_rx,
	// status
	output logic               o_busy,
	output logic               o_done,
	output logic               o_fail,
	output logic [3:0]         o_nak_count,
	output logic               o_boot_enable_level
);
	// ****************************************
	// state and storage
	// ****************************************
	typedef enum logic [7:0] {
		S_IDLE     = 8'h01,
		S_RESET    = 8'h02,
		S_EXT_WAIT = 8'h04,
		S_WAIT_STX = 8'h08,
		S_SEND     = 8'h10,
		S_QUIET    = 8'h20,
		S_DONE     = 8'h40,
		S_FAIL     = 8'h80
	} fbl_state_type;

	logic [7:0]    image_mem [0:MAX_IMAGE_BYTES-1];  // firmware image to upload
	fbl_state_type state_q, state_d;                 // sequencer state
	logic [31:0]   timer_q, timer_d;                 // shared down counter
	logic [15:0]   pos_q, pos_d;                     // position in upload sequence
	logic [15:0]   len_q, len_d;                     // image bytes, crc excluded
	logic [15:0]   crc_q, crc_d;                     // running crc of image bytes
	logic          ce_pend_q, ce_pend_d;             // clear-error to lead next try
	logic [3:0]    nak_q, nak_d;                     // NAKs seen this boot
	logic [11:0]   div_q, div_d;                     // clocks per bit
	logic          tx_load_q, tx_load_d;             // one-cycle byte launch
	logic [7:0]    tx_byte_q, tx_byte_d;             // byte being launched
	fbl_strap_type strap_q, strap_d;
	logic          rst_n_q, rst_n_d, en_out_q, en_out_d, en_oe_q, en_oe_d;
	logic [15:0]   size_field;                       // announced size incl. crc
	logic [14:0]   rd_idx;                           // image byte now due
	logic [16:0]   need_len;                         // length check at start

	// transmitter, receiver and synchroniser state
	logic          tx_busy_q, tx_busy_d, tx_out_q, tx_out_d;
	logic [8:0]    tx_sh_q, tx_sh_d;
	logic [3:0]    tx_cnt_q, tx_cnt_d;
	logic [11:0]   tx_baud_q, tx_baud_d;
	logic          rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_lvl_d;
	logic          gp_s1_q, gp_s2_q, gp_s3_q, gp_lvl_q, gp_lvl_d;
	logic          rx_act_q, rx_act_d, rx_vld_q, rx_vld_d;
	logic [11:0]   rx_cnt_q, rx_cnt_d;
	logic [3:0]    rx_bit_q, rx_bit_d;
	logic [7:0]    rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;

	assign size_field = len_q + 16'(CRC_BYTES);
	assign rd_idx     = 15'(pos_q - 16'h0003);
	assign need_len   = {1'b0, i_image_len} + 17'(CRC_BYTES);

	// ****************************************
	// image memory write port
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_img_we) begin
			image_mem[i_img_addr] <= i_img_data;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	// next-state logic for straps, reset and the upload sequence
	always_comb begin
		state_d   = state_q;
		timer_d   = timer_q;
		pos_d     = pos_q;
		len_d     = len_q;
		crc_d     = crc_q;
		ce_pend_d = ce_pend_q;
		nak_d     = nak_q;
		div_d     = div_q;
		tx_load_d = 1'b0;
		tx_byte_d = tx_byte_q;
		strap_d   = strap_q;
		rst_n_d   = rst_n_q;
		en_out_d  = en_out_q;
		en_oe_d   = en_oe_q;
		case (state_q)
			S_IDLE, S_DONE, S_FAIL: begin
				if (i_start) begin
					// straps settle while the modem is held in reset
					strap_d.boot_source_select = i_from_memory;
					strap_d.baud_select_high   = i_baud_code[1];
					strap_d.baud_select_low    = i_baud_code[0];
					div_d     = baud_div(i_baud_code);
					en_out_d  = 1'b0;
					en_oe_d   = 1'b1;
					rst_n_d   = 1'b0;
					len_d     = i_image_len;
					nak_d     = 4'h0;
					ce_pend_d = 1'b0;
					timer_d   = 32'(RST_HOLD_CYC);
					state_d   = S_RESET;
					// in a serial boot an empty or oversized image is refused before the modem sees it
					if (!i_from_memory && (i_image_len == 16'h0000
						|| need_len > 17'(MAX_IMAGE_BYTES))) begin
						en_oe_d = 1'b0;
						state_d = S_FAIL;
					end
				end
			end
			S_RESET: begin
				if (timer_q == 32'h0) begin
					rst_n_d = 1'b1;
					timer_d = strap_q.boot_source_select ? 32'(EXT_WAIT_CYCLES)
						: 32'(STX_WAIT_CYCLES);
					state_d = strap_q.boot_source_select ? S_EXT_WAIT : S_WAIT_STX;
				end else begin
					timer_d = timer_q - 32'h1;
				end
			end
			S_EXT_WAIT: begin
				// nothing comes back from a memory boot; just let it settle
				// image layout in memory (base zero, zero fill, trailer) is the memory
				// programmer's job; this block only straps and resets
				if (timer_q == 32'h0) begin
					en_oe_d = 1'b0;
					state_d = S_DONE;
				end else begin
					timer_d = timer_q - 32'h1;
				end
			end
			S_WAIT_STX: begin
				// nothing is sent until the modem announces it is ready
				if (rx_vld_q && rx_byte_q == STX_BYTE) begin
					pos_d   = 16'h0000;
					crc_d   = CRC_INIT;
					state_d = S_SEND;
				end else if (timer_q == 32'h0) begin
					state_d = S_FAIL;
				end else begin
					timer_d = timer_q - 32'h1;
				end
			end
			S_SEND: begin
				// bytes leave back to back, far inside the start and gap limits
				if (!tx_load_q && !tx_busy_q) begin
					tx_load_d = 1'b1;
					if (ce_pend_q) begin
						tx_byte_d = CLEAR_ERR_BYTE;
						ce_pend_d = 1'b0;
					end else begin
						pos_d = pos_q + 16'h0001;
						if (pos_q == 16'h0000) begin
							tx_byte_d = MAGIC_BYTE;
						end else if (pos_q == 16'h0001) begin
							tx_byte_d = size_field[7:0];
						end else if (pos_q == 16'h0002) begin
							tx_byte_d = size_field[15:8];
						end else if (pos_q == len_q + 16'h0003) begin
							tx_byte_d = crc_q[7:0];
						end else if (pos_q == len_q + 16'h0004) begin
							tx_byte_d = crc_q[15:8];
							timer_d   = 32'(DONE_QUIET_CYCLES);
							state_d   = S_QUIET;
						end else begin
							tx_byte_d = image_mem[rd_idx];
							crc_d     = crc_step(crc_q, image_mem[rd_idx], CRC_POLY);
						end
					end
				end
			end
			S_QUIET: begin
				// success once the line stays free of NAK after the last byte
				if (tx_load_q || tx_busy_q) begin
					timer_d = 32'(DONE_QUIET_CYCLES);
				end else if (timer_q == 32'h0) begin
					en_oe_d = 1'b0;
					state_d = S_DONE;
				end else begin
					timer_d = timer_q - 32'h1;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		// a NAK restarts the upload until MAX_RETRY restarts are spent, then fails the boot; the modem waits for quiet, then sends STX
		if ((state_q == S_WAIT_STX || state_q == S_SEND || state_q == S_QUIET)
			&& rx_vld_q && rx_byte_q == NAK_BYTE) begin
			tx_load_d = 1'b0;     // no fresh byte once the modem has refused
			nak_d     = nak_q + 4'h1;
			ce_pend_d = 1'b1;
			timer_d   = 32'(STX_WAIT_CYCLES);
			state_d   = (nak_q == MAX_RETRY) ? S_FAIL : S_WAIT_STX;
		end
		// user abort in a serial boot: raising the enable pin stops the modem loader at once
		if (i_abort && (state_q == S_RESET || state_q == S_WAIT_STX
			|| state_q == S_SEND || state_q == S_QUIET) && !strap_q.boot_source_select) begin
			en_out_d = 1'b1;
			state_d  = S_FAIL;
		end
	end

	// sequencer registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q   <= S_IDLE;
			timer_q   <= 32'h0;
			pos_q     <= 16'h0000;
			len_q     <= 16'h0000;
			crc_q     <= 16'h0000;
			ce_pend_q <= 1'b0;
			nak_q     <= 4'h0;
			div_q     <= DIV_115200;
			tx_load_q <= 1'b0;
			tx_byte_q <= 8'h00;
			strap_q   <= '0;
			rst_n_q   <= 1'b0;    // modem held in reset until started
			en_out_q  <= 1'b0;
			en_oe_q   <= 1'b0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_fail    <= 1'b0;
		end else begin
			state_q   <= state_d;
			timer_q   <= timer_d;
			pos_q     <= pos_d;
			len_q     <= len_d;
			crc_q     <= crc_d;
			ce_pend_q <= ce_pend_d;
			nak_q     <= nak_d;
			div_q     <= div_d;
			tx_load_q <= tx_load_d;
			tx_byte_q <= tx_byte_d;
			strap_q   <= strap_d;
			rst_n_q   <= rst_n_d;
			en_out_q  <= en_out_d;
			en_oe_q   <= en_oe_d;
			o_busy    <= !(state_d == S_IDLE || state_d == S_DONE || state_d == S_FAIL);
			o_done    <= state_d == S_DONE;
			o_fail    <= state_d == S_FAIL;
		end
	end

	// ****************************************
	// serial transmitter
	// ****************************************
	// start bit, eight data bits lsb first, one stop bit
	always_comb begin
		tx_busy_d = tx_busy_q;
		tx_out_d  = tx_out_q;
		tx_sh_d   = tx_sh_q;
		tx_cnt_d  = tx_cnt_q;
		tx_baud_d = tx_baud_q;
		if (tx_load_q) begin
			tx_busy_d = 1'b1;
			tx_out_d  = 1'b0;
			tx_sh_d   = {1'b1, tx_byte_q};
			tx_cnt_d  = 4'h9;
			tx_baud_d = div_q - 12'h001;
		end else if (tx_busy_q) begin
			if (tx_baud_q != 12'h000) begin
				tx_baud_d = tx_baud_q - 12'h001;
			end else if (tx_cnt_q == 4'h0) begin
				tx_busy_d = 1'b0;     // stop bit has had its full time
				tx_out_d  = 1'b1;
			end else begin
				tx_out_d  = tx_sh_q[0];
				tx_sh_d   = {1'b1, tx_sh_q[8:1]};
				tx_cnt_d  = tx_cnt_q - 4'h1;
				tx_baud_d = div_q - 12'h001;
			end
		end
	end

	// transmitter registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_busy_q <= 1'b0;
			tx_out_q  <= 1'b1;
			tx_sh_q   <= 9'h1FF;
			tx_cnt_q  <= 4'h0;
			tx_baud_q <= 12'h000;
		end else begin
			tx_busy_q <= tx_busy_d;
			tx_out_q  <= tx_out_d;
			tx_sh_q   <= tx_sh_d;
			tx_cnt_q  <= tx_cnt_d;
			tx_baud_q <= tx_baud_d;
		end
	end

	// ****************************************
	// pin synchronisers and serial receiver
	// ****************************************
	// a level changes only once the second and third stages agree
	always_comb begin
		rx_lvl_d = (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_lvl_q;
		gp_lvl_d = (gp_s2_q == gp_s3_q) ? gp_s3_q : gp_lvl_q;
		rx_act_d  = rx_act_q;
		rx_cnt_d  = rx_cnt_q;
		rx_bit_d  = rx_bit_q;
		rx_sh_d   = rx_sh_q;
		rx_byte_d = rx_byte_q;
		rx_vld_d  = 1'b0;
		if (!rx_act_q) begin
			if (!rx_lvl_q) begin
				// sample at mid-bit from here on
				rx_act_d = 1'b1;
				rx_cnt_d = {1'b0, div_q[11:1]};
				rx_bit_d = 4'h0;
			end
		end else if (rx_cnt_q != 12'h000) begin
			rx_cnt_d = rx_cnt_q - 12'h001;
		end else begin
			rx_cnt_d = div_q - 12'h001;
			if (rx_bit_q == 4'h0) begin
				rx_act_d = !rx_lvl_q;     // a short low pulse is not a start bit
				rx_bit_d = 4'h1;
			end else if (rx_bit_q != 4'h9) begin
				rx_sh_d  = {rx_lvl_q, rx_sh_q[7:1]};
				rx_bit_d = rx_bit_q + 4'h1;
			end else begin
				rx_act_d = 1'b0;
				if (rx_lvl_q) begin       // framing error drops the byte
					rx_vld_d  = 1'b1;
					rx_byte_d = rx_sh_q;
				end
			end
		end
	end

	// synchroniser and receiver registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_s3_q   <= 1'b1;
			rx_lvl_q  <= 1'b1;
			gp_s1_q   <= 1'b0;
			gp_s2_q   <= 1'b0;
			gp_s3_q   <= 1'b0;
			gp_lvl_q  <= 1'b0;
			rx_act_q  <= 1'b0;
			rx_cnt_q  <= 12'h000;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_vld_q  <= 1'b0;
		end else begin
			rx_s1_q   <= i_uart_rx;
			rx_s2_q   <= rx_s1_q;
			rx_s3_q   <= rx_s2_q;
			rx_lvl_q  <= rx_lvl_d;
			gp_s1_q   <= i_boot_enable_gpio;
			gp_s2_q   <= gp_s1_q;
			gp_s3_q   <= gp_s2_q;
			gp_lvl_q  <= gp_lvl_d;
			rx_act_q  <= rx_act_d;
			rx_cnt_q  <= rx_cnt_d;
			rx_bit_q  <= rx_bit_d;
			rx_sh_q   <= rx_sh_d;
			rx_byte_q <= rx_byte_d;
			rx_vld_q  <= rx_vld_d;
		end
	end

	// outputs straight from registers
	assign o_modem_reset_n        = rst_n_q;
	assign o_strap                = strap_q;
	assign o_boot_enable_gpio_out = en_out_q;
	assign o_boot_enable_gpio_oe  = en_oe_q;
	assign o_uart_tx              = tx_out_q;
	assign o_nak_count            = nak_q;
	assign o_boot_enable_level    = gp_lvl_q;
endmodule // fbl_host_loader
`default_nettype wire

// file: verilog/fbl_pkg.sv
// fbl_pkg: constants, types and helpers for the firmware upload controller
`default_nettype none
package fbl_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ          = 20_000_000;                 // system clock rate
	localparam int unsigned RST_HOLD_US     = 10;                         // modem reset pulse, us
	localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned START_LIMIT_MS  = 350;                        // first byte after STX
	localparam int unsigned GAP_LIMIT_MS    = 20;                         // between host bytes
	localparam int unsigned NAK_QUIET_MS    = 100;                        // modem idle wait
	localparam int unsigned STX_WAIT_MS     = 1000;                       // give up waiting STX
	localparam int unsigned STX_WAIT_CYC    = STX_WAIT_MS * (CLK_HZ / 1000);
	localparam int unsigned DONE_QUIET_MS   = 50;                         // no NAK => success
	localparam int unsigned DONE_QUIET_CYC  = DONE_QUIET_MS * (CLK_HZ / 1000);
	localparam int unsigned EXT_WAIT_MS     = 500;                        // memory boot settle
	localparam int unsigned EXT_WAIT_CYC    = EXT_WAIT_MS * (CLK_HZ / 1000);

	// ****************************************
	// serial protocol bytes and limits
	// ****************************************
	localparam logic [7:0]  STX_BYTE        = 8'h02;
	localparam logic [7:0]  NAK_BYTE        = 8'h15;
	localparam logic [7:0]  MAGIC_BYTE      = 8'hAA;
	localparam logic [7:0]  CLEAR_ERR_BYTE  = 8'hCE;
	localparam int unsigned CRC_BYTES       = 2;                          // counted in size field
	localparam int unsigned MAX_IMAGE       = 32512;                      // 0x7F00 byte ceiling
	localparam logic [15:0] CRC_POLY_DEF    = 16'h1021;
	localparam logic [15:0] CRC_INIT_DEF    = 16'hFFFF;

	// ****************************************
	// baud select strap codes {high,low}
	// ****************************************
	localparam logic [1:0]  BAUD_CODE_115200 = 2'h0;
	localparam logic [1:0]  BAUD_CODE_9600   = 2'h1;
	localparam logic [1:0]  BAUD_CODE_19200  = 2'h2;
	localparam logic [1:0]  BAUD_CODE_38400  = 2'h3;
	localparam logic [11:0] DIV_115200 = 12'((CLK_HZ + 115200 / 2) / 115200);
	localparam logic [11:0] DIV_9600   = 12'((CLK_HZ + 9600 / 2) / 9600);
	localparam logic [11:0] DIV_19200  = 12'((CLK_HZ + 19200 / 2) / 19200);
	localparam logic [11:0] DIV_38400  = 12'((CLK_HZ + 38400 / 2) / 38400);

	// strap pins driven into the modem before its reset is released
	typedef struct packed {
		logic boot_source_select;   // high: boot from memory
		logic baud_select_high;
		logic baud_select_low;
	} fbl_strap_type;

	// clocks per bit for a strap code
	function automatic logic [11:0] baud_div(input logic [1:0] code);
		case (code)
			BAUD_CODE_9600:  baud_div = DIV_9600;
			BAUD_CODE_19200: baud_div = DIV_19200;
			BAUD_CODE_38400: baud_div = DIV_38400;
			default:         baud_div = DIV_115200;
		endcase
	endfunction

	// one byte of a msb-first crc16, polynomial chosen by caller
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data,
		input logic [15:0] poly);
		logic [15:0] c;
		c = crc ^ {data, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ poly) : (c << 1);
		end
		crc_step = c;
	endfunction
endpackage
`default_nettype wire
